// ---- logic/dpl_converter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dpl_defines.svh"

// Overview of operation
// [RULE1] twelve data bits plus one sample clock
// [RULE2] unsigned binary, bit eleven is msb
// [RULE3] all ones gives full scale on primary
// [RULE4] edge-triggered master-slave capture of word
// [RULE5] output changes only after rising clock edge
// [RULE6] sample clock up to 125 MSPS; source and edge detect here reach only sys/2 = 62.5 MSPS
// [RULE7] any duty cycle meeting minimum pulse widths
// [RULE8] source changes data on falling edge
// [RULE9] primary code/4096, complement (4095-code)/4096
// [RULE10] sleep high turns output current off
// [RULE11] decoder code steady between rising edges
module dpl_converter
  import dpl_pkg::*;
#(
  parameter int unsigned FS_W = `DPL_FS_W
)
(
  input  wire logic            CLK_SYS_I,   // system clock
  input  wire logic            RESETN_I,    // async reset, low
  input  wire logic            CE_I,        // clock enable
  input  wire logic [FS_W-1:0] FULL_SCALE_CURRENT_I, // full-scale level
  output logic [FS_W-1:0]      PRIMARY_CURRENT_OUT_O,    // primary level
  output logic [FS_W-1:0]      COMPLEMENT_CURRENT_OUT_O, // complement level
  output logic [`DPL_DATA_W-1:0] CODE_O,    // held code
  output logic                 UPDATE_O,    // output update pulse
  dpl_link_if.conv             link
);

  localparam int unsigned PW = FS_W + `DPL_DATA_W;

  logic            clk_q_ff;
  logic            sleep_q_ff;
  dpl_code_t       master_ff;
  dpl_code_t       slave_ff;
  logic            upd_ff;
  logic [FS_W-1:0] pri_ff;
  logic [FS_W-1:0] cmp_ff;
  logic            rise;
  logic [PW-1:0]   fs_wide;
  logic [PW-1:0]   acc_pri [0:`DPL_DATA_W];
  logic [PW-1:0]   acc_cmp [0:`DPL_DATA_W];
  logic [FS_W-1:0] nxt_pri;
  logic [FS_W-1:0] nxt_cmp;

  // inputs are synchronous to the system clock; sample clock edge detect
  assign rise = link.sample_clk & ~clk_q_ff;

  // last clock level, resets to the idle low so no false edge follows reset
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      clk_q_ff <= 1'b0;
    end
    else if (CE_I)
    begin
      clk_q_ff <= link.sample_clk;
    end
  end

  // sleep level, one register ahead of the output gate
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      sleep_q_ff <= 1'b0;
    end
    else if (CE_I)
    begin
      sleep_q_ff <= link.sleep;
    end
  end

  // master follows data only while clock low, so moves while high are ignored
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      master_ff <= `DPL_CODE_RST;
    end
    else if (CE_I)
    begin
      if (!link.sample_clk)
      begin
        master_ff <= link.data_word; // see [RULE4]
      end
    end
  end

  // slave takes the master at the rising edge and holds it until the next
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      slave_ff <= `DPL_CODE_RST;
    end
    else if (CE_I)
    begin
      if (rise)
      begin
        slave_ff <= master_ff; // see [RULE4] see [RULE5] see [RULE11]
      end
    end
  end

  // one-cycle mark of a newly held code
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      upd_ff <= 1'b0;
    end
    else if (CE_I)
    begin
      upd_ff <= rise;
    end
  end

  assign fs_wide    = PW'(FULL_SCALE_CURRENT_I);
  assign acc_pri[0] = '0;
  assign acc_cmp[0] = '0;

  // one switch per code bit steers weight fs*2^b to one output (see [RULE2])
  for (genvar b = 0; b < `DPL_DATA_W; b++)
  begin : g_switch
    logic [PW-1:0] weight;
    assign weight       = fs_wide << b;
    assign acc_pri[b+1] = slave_ff[b] ? acc_pri[b] + weight : acc_pri[b];
    assign acc_cmp[b+1] = slave_ff[b] ? acc_cmp[b] : acc_cmp[b] + weight;
  end : g_switch

  // fraction dropped once, at the chain end, so both floors stay exact
  always_comb
  begin
    nxt_pri = acc_pri[`DPL_DATA_W][PW-1:`DPL_DATA_W]; // see [RULE9] see [RULE3]
    if (sleep_q_ff)
    begin
      nxt_pri = '0; // see [RULE10]
    end
  end

  always_comb
  begin
    nxt_cmp = acc_cmp[`DPL_DATA_W][PW-1:`DPL_DATA_W]; // see [RULE9]
    if (sleep_q_ff)
    begin
      nxt_cmp = '0; // see [RULE10]
    end
  end

  // outputs follow the slave one cycle after the rising edge (see [RULE5])
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      pri_ff <= '0;
    end
    else if (CE_I)
    begin
      pri_ff <= nxt_pri;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      cmp_ff <= '0;
    end
    else if (CE_I)
    begin
      cmp_ff <= nxt_cmp;
    end
  end

  assign PRIMARY_CURRENT_OUT_O    = pri_ff;
  assign COMPLEMENT_CURRENT_OUT_O = cmp_ff;
  assign CODE_O                   = slave_ff;
  assign UPDATE_O                 = upd_ff;

endmodule : dpl_converter

`default_nettype wire

// ---- logic/dpl_defines.svh ----
`ifndef DPL_DEFINES_SVH
`define DPL_DEFINES_SVH

`define DPL_DATA_W        12
`define DPL_CODE_MAX      12'hfff
`define DPL_CODE_RST      12'h000
`define DPL_CODE_SPAN     13'h1000
`define DPL_FS_W          16
`define DPL_MAX_RATE_MSPS 125
`define DPL_SYS_MHZ       125
`define DPL_DIV_DEFAULT   2

`endif

// ---- logic/dpl_pkg.sv ----
`default_nettype none
`include "dpl_defines.svh"

package dpl_pkg;

  typedef logic [`DPL_DATA_W-1:0] dpl_code_t;

  typedef enum logic [1:0]
  {
    DPL_PH_LOW  = 2'b00,
    DPL_PH_HIGH = 2'b01
  } dpl_phase_t;

endpackage : dpl_pkg

`default_nettype wire

// ---- logic/dpl_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dpl_defines.svh"

interface dpl_link_if;
  logic [`DPL_DATA_W-1:0] data_word;
  logic                   sample_clk;
  logic                   sleep;

  modport source (output data_word, output sample_clk, output sleep);
  modport conv   (input data_word, input sample_clk, input sleep);
endinterface : dpl_link_if

`default_nettype wire

// ---- logic/dpl_source.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dpl_defines.svh"

module dpl_source
  import dpl_pkg::*;
#(
  parameter int unsigned DIV_HALF = `DPL_DIV_DEFAULT
)
(
  input  wire logic               CLK_SYS_I,   // system clock
  input  wire logic               RESETN_I,    // async reset, low
  input  wire logic               CE_I,        // clock enable
  input  wire logic [`DPL_DATA_W-1:0] SAMPLE_I, // next sample
  input  wire logic               SLEEP_I,     // power-down request
  output logic                    TAKEN_O,     // sample consumed pulse
  dpl_link_if.source              link
);

  localparam int unsigned DH = (DIV_HALF < 1) ? 1 : DIV_HALF;

  logic [15:0]      cnt_ff;
  dpl_phase_t       phase_ff;
  dpl_code_t        data_ff;
  logic             sleep_ff;
  logic             taken_ff;

  // half-period counter; clock never exceeds sys/2 = 62.5 MSPS (see [RULE6])
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      cnt_ff   <= 16'h0000;
      phase_ff <= DPL_PH_LOW;
    end
    else if (CE_I)
    begin
      if (cnt_ff == 16'(DH - 1))
      begin
        cnt_ff   <= 16'h0000;
        phase_ff <= (phase_ff == DPL_PH_LOW) ? DPL_PH_HIGH : DPL_PH_LOW; // see [RULE7]
      end
      else
      begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end

  // data changes when clock falls, equal high and low (see [RULE8])
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      data_ff  <= `DPL_CODE_RST;
      sleep_ff <= 1'b0;
      taken_ff <= 1'b0;
    end
    else if (CE_I)
    begin
      sleep_ff <= SLEEP_I;
      taken_ff <= 1'b0;
      if (cnt_ff == 16'(DH - 1) && phase_ff == DPL_PH_HIGH)
      begin
        data_ff  <= SAMPLE_I; // all twelve bits driven (see [RULE1])
        taken_ff <= 1'b1;
      end
    end
  end

  assign link.data_word  = data_ff;
  assign link.sample_clk = (phase_ff == DPL_PH_HIGH);
  assign link.sleep      = sleep_ff;
  assign TAKEN_O         = taken_ff;

endmodule : dpl_source

`default_nettype wire

// ---- bench/dpl_link_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dpl_defines.svh"

module dpl_link_checker
#(
  parameter int DIV_HALF = 2
)
(
  input wire logic                   CLK_SYS_I,  // system clock
  input wire logic                   RESETN_I,   // async reset, low
  input wire logic                   CE_I,       // clock enable
  input wire logic [`DPL_DATA_W-1:0] data_word,  // link word
  input wire logic                   sample_clk  // link clock
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  // link checks are abandoned while enable is low; their delays still count every system cycle
  default disable iff (!RESETN_I || !CE_I);

  AST_DATA_ON_FALL: assert property ($changed(data_word) |-> $fell(sample_clk))
    else $error("word moved off a clock fall");
  AST_DATA_STEADY: assert property (sample_clk |-> $stable(data_word))
    else $error("word moved while clock high");
  AST_WORD_HELD: assert property ($fell(sample_clk) |=> $stable(data_word) [*3])
    else $error("word not held for the sample");
  AST_HIGH_MIN: assert property ($rose(sample_clk) |=> sample_clk)
    else $error("clock high too short");
  AST_LOW_MIN: assert property ($fell(sample_clk) |=> !sample_clk)
    else $error("clock low too short");
  AST_RATE: assert property ($rose(sample_clk) |=> !$rose(sample_clk) [*3])
    else $error("clock rises too often");
  AST_HIGH_TIME: assert property ($rose(sample_clk) |-> ##DIV_HALF $fell(sample_clk))
    else $error("clock high time wrong");
  AST_LOW_TIME: assert property ($fell(sample_clk) |-> ##DIV_HALF $rose(sample_clk))
    else $error("clock low time wrong");
endmodule : dpl_link_checker

`default_nettype wire

// ---- bench/dac_parallel_input_latch_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dpl_defines.svh"

module dac_parallel_input_latch_bench;
  import dpl_pkg::*;
  logic        clk = 0, rst_n = 0, slp = 0, ce = 1, taken, upd;
  dpl_code_t   smp = 12'h000, code, code_b;
  dpl_code_t   codes [6] = '{12'h000, 12'hfff, 12'h800, 12'h001, 12'h7ff, 12'ha5a};
  logic [15:0] fs = 16'hc351, pri, cmp;
  int          n_fail = 0, comparisons = 0;
  dpl_link_if link ();
  dpl_link_if link_b ();
  dpl_source #(.DIV_HALF(2)) i_dpl_source (.CLK_SYS_I(clk), .RESETN_I(rst_n), .CE_I(ce), .SAMPLE_I(smp),
    .SLEEP_I(slp), .TAKEN_O(taken), .link(link));
  dpl_converter i_dpl_converter (.CLK_SYS_I(clk), .RESETN_I(rst_n), .CE_I(ce), .FULL_SCALE_CURRENT_I(fs),
    .PRIMARY_CURRENT_OUT_O(pri), .COMPLEMENT_CURRENT_OUT_O(cmp), .CODE_O(code), .UPDATE_O(upd), .link(link));
  dpl_converter i_dpl_converter_b (.CLK_SYS_I(clk), .RESETN_I(rst_n), .CE_I(ce), .FULL_SCALE_CURRENT_I(fs),
    .PRIMARY_CURRENT_OUT_O(), .COMPLEMENT_CURRENT_OUT_O(), .CODE_O(code_b), .UPDATE_O(), .link(link_b));
  dpl_link_checker #(.DIV_HALF(2)) i_dpl_link_checker (.CLK_SYS_I(clk), .RESETN_I(rst_n), .CE_I(ce),
    .data_word(link.data_word), .sample_clk(link.sample_clk));

  initial
  forever #4 clk = ~clk;

  task automatic conclude;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic wait_for(input bit for_upd);
    for (int i = 0; i < 20; i++)
    begin
      @(negedge clk);
      if ((for_upd ? upd : taken) === 1'b1)
        return;
    end
    n_fail++;
    conclude();
  endtask : wait_for

  task automatic send(input dpl_code_t c);
    smp = c;
    @(negedge clk);
    wait_for(0);
    wait_for(1);
    check({4'h0, code}, {4'h0, c});
    @(negedge clk);
    check(pri, 16'((32'(fs) * c) >> 12));
    check(cmp, 16'((32'(fs) * (12'hfff - c)) >> 12));
  endtask : send

  initial
  begin
    link_b.data_word = 12'h000;
    link_b.sample_clk = 0;
    link_b.sleep = 0;
    repeat (5) @(negedge clk);
    rst_n = 1;
    foreach (codes[i]) send(codes[i]);
    slp = 1;
    repeat (4) @(negedge clk);
    check(pri, 16'h0000);
    check(cmp, 16'h0000);
    slp = 0;
    send(12'h3c3);
    // enable low: a waiting sample must not reach the outputs
    ce = 0;
    smp = 12'h0aa;
    repeat (12) @(negedge clk);
    check({4'h0, code}, 16'h03c3);
    check(pri, 16'((32'(fs) * 12'h3c3) >> 12));
    ce = 1;
    send(12'h0aa);
    // mid-run reset clears the held code and both currents
    rst_n = 0;
    repeat (2) @(negedge clk);
    check({4'h0, code}, 16'h0000);
    check(pri, 16'h0000);
    check(cmp, 16'h0000);
    rst_n = 1;
    send(12'h801);
    // far end changes data while its clock is high
    link_b.data_word = 12'h5a5;
    repeat (2) @(negedge clk);
    link_b.sample_clk = 1;
    @(negedge clk);
    link_b.data_word = 12'h0f0;
    repeat (3) @(negedge clk);
    check({4'h0, code_b}, 16'h05a5);
    conclude();
  end
endmodule : dac_parallel_input_latch_bench

`default_nettype wire
